// ===== timer8_params.svh
// Offsets, fields, reset values and prescaler width of the 8-bit timer core.
// Assumes inclusion by bare name from every file that needs the numbers.
//
// Contract
// - Counter and both compare registers are eight bits, read and write.
// - Exactly three interrupt sources: overflow, match A, match B.
// - All three requests visible as flags in one readable flag register.
// - Each request has its own mask bit in the mask register.
// - Tick from prescaled system clock or external pin; select picks source and edge.
// - Select value zero gives no ticks; counter holds its value.
// - Both compare values compared with the count continuously; match drives waveform side.
// - A compare match sets that unit's flag, which may raise its request.
// - Bottom is count 0x00; bottom indication while counter holds zero.
// - Maximum count is 0xFF in every mode.
// - Top is 0xFF or compare A by mode; reaching it asserts top.
// - Each tick clears, increments or decrements by one per mode and direction.
// - Counter readable and writable whether or not ticks occur.
// - Counter write beats a coincident clear or count.
// - Three-bit mode field: low two bits in control A, high bit in B.
// - Overflow flag set at the mode's overflow point; may raise request.
// - Select 1 every clock; 8,64,256,1024 taps; 6/7 falling/rising pin edges.
// - Normal mode counts up, wraps 0xFF to 0x00, overflow when zero.
// - Match flag set in tick after match; write one or service clears it.
// - Counter write blocks compare matches in the next tick, even when stopped.
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_COUNT 8'h08
`define OFF_CMP_A 8'h0C
`define OFF_CMP_B 8'h10
`define OFF_MASK 8'h14
`define OFF_FLAG 8'h18
`define WM2_BIT 3
`define DIR_BIT 7
`define IRQ_OVF 0
`define IRQ_CMP_A 1
`define IRQ_CMP_B 2
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
`define COUNT_ONE 8'h01
`define RST_BYTE 8'h00
`define RST_IRQ 3'h0
`define PRE_W 10
`endif

// ===== timer8_pkg.sv
// Types shared by the timer core and its tick selector.
// Assumes the constants come from timer8_params.svh.
package timer8_pkg;
  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0, WM_PC_MAX = 3'h1, WM_CLEAR_MATCH = 3'h2, WM_FAST_MAX = 3'h3,
    WM_RSV4 = 3'h4, WM_PC_CMPA = 3'h5, WM_RSV6 = 3'h6, WM_FAST_CMPA = 3'h7
  } wave_mode_e;
  typedef enum logic [2:0] {
    TS_STOP = 3'h0, TS_DIV1 = 3'h1, TS_DIV8 = 3'h2, TS_DIV64 = 3'h3,
    TS_DIV256 = 3'h4, TS_DIV1024 = 3'h5, TS_EXT_FALL = 3'h6, TS_EXT_RISE = 3'h7
  } tick_sel_e;
endpackage

// ===== timer8_tick_select.sv
// Tick source selection: free-running prescaler and external pin edge detect.
// Assumes hclk is the system clock and ext_count_pin is asynchronous.
`timescale 1ns/1ps
`include "timer8_params.svh"
module timer8_tick_select (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire timer8_pkg::tick_sel_e tick_source_sel, // Source and edge select
  input wire logic ext_count_pin, // External count pin, asynchronous
  output logic timer_tick // One-cycle tick enable
);
  logic [`PRE_W-1:0] pres_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;

  // Free-running prescaler, unaffected by the select
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pres_reg <= '0;
    else
      pres_reg <= pres_reg + `PRE_W'(1);

  // Two-flop synchroniser plus one stage for edge detection
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= ext_count_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end

  // Tap and edge strobes
  wire tap_8 = &pres_reg[2:0];
  wire tap_64 = &pres_reg[5:0];
  wire tap_256 = &pres_reg[7:0];
  wire tap_1024 = &pres_reg[9:0];
  wire pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire pin_fall = ~pin_s2_reg & pin_s3_reg;

  // Source multiplexer
  always_comb
    case (tick_source_sel)
      timer8_pkg::TS_STOP: timer_tick = 1'b0;
      timer8_pkg::TS_DIV1: timer_tick = 1'b1;
      timer8_pkg::TS_DIV8: timer_tick = tap_8;
      timer8_pkg::TS_DIV64: timer_tick = tap_64;
      timer8_pkg::TS_DIV256: timer_tick = tap_256;
      timer8_pkg::TS_DIV1024: timer_tick = tap_1024;
      timer8_pkg::TS_EXT_FALL: timer_tick = pin_fall;
      timer8_pkg::TS_EXT_RISE: timer_tick = pin_rise;
      default: timer_tick = 1'b0;
    endcase

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_stop_no_tick: assert property (tick_source_sel == timer8_pkg::TS_STOP |-> !timer_tick)
    else $error("Tick while source stopped");
  a_div8_spacing: assert property (
    tick_source_sel == timer8_pkg::TS_DIV8 && timer_tick
      |=> (!timer_tick || tick_source_sel != timer8_pkg::TS_DIV8)[*7])
    else $error("Divide-by-8 tick spacing wrong");
  a_ext_rise_tick: assert property (
    tick_source_sel == timer8_pkg::TS_EXT_RISE && pin_s2_reg && !pin_s3_reg |-> timer_tick)
    else $error("Rising pin edge gave no tick");
  c_ext_fall: cover property (tick_source_sel == timer8_pkg::TS_EXT_FALL && timer_tick);
endmodule // timer8_tick_select

// ===== timer8_counter_core.sv
// Eight-bit timer/counter core with AHB-Lite register access.
// Assumes a single AHB-Lite master; hreadyout is the bus hready.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "timer8_params.svh"
module timer8_counter_core (
  input wire logic hclk, // System clock, 40 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic ext_count_pin, // External count pin
  input wire logic [2:0] irq_ack, // Service pulses clearing flags
  output logic irq_ovf, // Overflow request
  output logic irq_match_a, // Compare A request
  output logic irq_match_b, // Compare B request
  output logic match_a_out, // Count equals compare A
  output logic match_b_out, // Count equals compare B
  output logic top_out, // Count at top
  output logic bottom_out, // Count at bottom
  output logic count_down_out // Counting direction down
);
  logic [1:0] wave_mode_lo_reg;
  logic wave_mode_bit2_reg;
  logic [2:0] tick_source_sel_reg;
  logic [7:0] count_value_reg;
  logic [7:0] compare_value_a_reg;
  logic [7:0] compare_value_b_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_flag_reg;
  logic dir_down_reg;
  logic block_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic [2:0] irq_out_reg;
  logic [3:0] stat_out_reg;
  logic dir_out_reg;
  logic timer_tick;
  logic [7:0] count_value_next;
  logic [2:0] irq_flag_next;
  logic [2:0] irq_mask_next;
  logic dir_down_next;
  logic [31:0] read_mux;

  // Write strobe for one register, used by every register
  function automatic logic reg_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
    reg_hit = pend && (a == off);
  endfunction

  // Bus address phase and write decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire wr_ctrl_a = reg_hit(wr_pend_reg, addr_reg, `OFF_CTRL_A);
  wire wr_ctrl_b = reg_hit(wr_pend_reg, addr_reg, `OFF_CTRL_B);
  wire wr_count = reg_hit(wr_pend_reg, addr_reg, `OFF_COUNT);
  wire wr_cmp_a = reg_hit(wr_pend_reg, addr_reg, `OFF_CMP_A);
  wire wr_cmp_b = reg_hit(wr_pend_reg, addr_reg, `OFF_CMP_B);
  wire wr_mask = reg_hit(wr_pend_reg, addr_reg, `OFF_MASK);
  wire wr_flag = reg_hit(wr_pend_reg, addr_reg, `OFF_FLAG);

  // Mode assembled from its two control registers
  wire timer8_pkg::wave_mode_e wave_mode_sel =
    timer8_pkg::wave_mode_e'({wave_mode_bit2_reg, wave_mode_lo_reg});
  wire is_pc = (wave_mode_sel == timer8_pkg::WM_PC_MAX)
    || (wave_mode_sel == timer8_pkg::WM_PC_CMPA);
  wire is_fast = (wave_mode_sel == timer8_pkg::WM_FAST_MAX)
    || (wave_mode_sel == timer8_pkg::WM_FAST_CMPA);
  wire top_is_cmp_a = (wave_mode_sel == timer8_pkg::WM_CLEAR_MATCH)
    || (wave_mode_sel == timer8_pkg::WM_PC_CMPA)
    || (wave_mode_sel == timer8_pkg::WM_FAST_CMPA);

  // Continuous compare and extreme-value detection
  wire [7:0] top_value = top_is_cmp_a ? compare_value_a_reg : `COUNT_MAX;
  wire at_top = (count_value_reg == top_value);
  wire at_bottom = (count_value_reg == `COUNT_BOTTOM);
  wire at_max = (count_value_reg == `COUNT_MAX);
  wire match_a = (count_value_reg == compare_value_a_reg);
  wire match_b = (count_value_reg == compare_value_b_reg);
  wire step_down = dir_down_reg ? !at_bottom : at_top;
  wire clear_at_top = !is_pc && at_top && (wave_mode_sel != timer8_pkg::WM_NORMAL);
  wire do_tick = timer_tick && !wr_count;

  // Event strobes that set the sticky flags
  wire ovf_evt = do_tick && (is_pc ? (step_down && count_value_reg == `COUNT_ONE)
    : is_fast ? at_top : at_max);
  wire cmp_a_evt = do_tick && match_a && !block_reg;
  wire cmp_b_evt = do_tick && match_b && !block_reg;
  wire [2:0] set_vec = {cmp_b_evt, cmp_a_evt, ovf_evt};
  wire [2:0] clr_vec = (wr_flag ? hwdata[2:0] : 3'h0) | irq_ack;

  timer8_tick_select u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_source_sel(timer8_pkg::tick_sel_e'(tick_source_sel_reg)),
    .ext_count_pin(ext_count_pin),
    .timer_tick(timer_tick)
  );

  // Next count: write first, then clear, step up or step down
  always_comb
  begin
    count_value_next = count_value_reg;
    dir_down_next = is_pc ? dir_down_reg : 1'b0;
    if (wr_count)
      count_value_next = hwdata[7:0];
    else if (timer_tick)
    begin
      if (is_pc)
      begin
        count_value_next = step_down ? count_value_reg - 8'h01 : count_value_reg + 8'h01;
        dir_down_next = step_down;
      end
      else if (clear_at_top)
        count_value_next = `COUNT_BOTTOM;
      else
        count_value_next = count_value_reg + 8'h01;
    end
  end

  // Flag and mask next values; a set beats a clear in the same cycle
  assign irq_flag_next = (irq_flag_reg & ~clr_vec) | set_vec;
  assign irq_mask_next = wr_mask ? hwdata[2:0] : irq_mask_reg;

  // Read multiplexer
  always_comb
    case (addr_reg)
      `OFF_CTRL_A: read_mux = {30'h0, wave_mode_lo_reg};
      `OFF_CTRL_B: read_mux = {24'h0, dir_down_reg, 3'h0, wave_mode_bit2_reg,
        tick_source_sel_reg};
      `OFF_COUNT: read_mux = {24'h0, count_value_reg};
      `OFF_CMP_A: read_mux = {24'h0, compare_value_a_reg};
      `OFF_CMP_B: read_mux = {24'h0, compare_value_b_reg};
      `OFF_MASK: read_mux = {29'h0, irq_mask_reg};
      `OFF_FLAG: read_mux = {29'h0, irq_flag_reg};
      default: read_mux = 32'h0;
    endcase

  // Bus phase tracking; a read takes one wait state
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= `RST_BYTE;
      hreadyout_reg <= 1'b1;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite;
      rd_pend_reg <= addr_phase & ~hwrite;
      hreadyout_reg <= ~(addr_phase & ~hwrite);
      if (addr_phase)
        addr_reg <= haddr[7:0];
    end

  // Read data loaded in the wait state
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata_reg <= 32'h0;
    else if (rd_pend_reg)
      hrdata_reg <= read_mux;

  // Control registers
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wave_mode_lo_reg <= 2'h0;
      wave_mode_bit2_reg <= 1'b0;
      tick_source_sel_reg <= 3'h0;
    end
    else
    begin
      if (wr_ctrl_a)
        wave_mode_lo_reg <= hwdata[1:0];
      if (wr_ctrl_b)
      begin
        wave_mode_bit2_reg <= hwdata[`WM2_BIT];
        tick_source_sel_reg <= hwdata[2:0];
      end
    end

  // Compare value registers
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      compare_value_a_reg <= `RST_BYTE;
      compare_value_b_reg <= `RST_BYTE;
    end
    else
    begin
      if (wr_cmp_a)
        compare_value_a_reg <= hwdata[7:0];
      if (wr_cmp_b)
        compare_value_b_reg <= hwdata[7:0];
    end

  // Counter, direction and match blocking
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      count_value_reg <= `RST_BYTE;
      dir_down_reg <= 1'b0;
      block_reg <= 1'b0;
    end
    else
    begin
      count_value_reg <= count_value_next;
      dir_down_reg <= dir_down_next;
      if (wr_count)
        block_reg <= 1'b1;
      else if (timer_tick)
        block_reg <= 1'b0;
    end

  // Flags, mask and request outputs
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      irq_flag_reg <= `RST_IRQ;
      irq_mask_reg <= `RST_IRQ;
      irq_out_reg <= `RST_IRQ;
    end
    else
    begin
      irq_flag_reg <= irq_flag_next;
      irq_mask_reg <= irq_mask_next;
      irq_out_reg <= irq_flag_next & irq_mask_next;
    end

  // Status toward the waveform generator, one cycle behind the count
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      stat_out_reg <= 4'h0;
      dir_out_reg <= 1'b0;
    end
    else
    begin
      stat_out_reg <= {at_bottom, at_top, match_b, match_a};
      dir_out_reg <= dir_down_reg;
    end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign irq_ovf = irq_out_reg[`IRQ_OVF];
  assign irq_match_a = irq_out_reg[`IRQ_CMP_A];
  assign irq_match_b = irq_out_reg[`IRQ_CMP_B];
  assign match_a_out = stat_out_reg[0];
  assign match_b_out = stat_out_reg[1];
  assign top_out = stat_out_reg[2];
  assign bottom_out = stat_out_reg[3];
  assign count_down_out = dir_out_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Counting, write priority, match blocking, compare B request, bottom indication and read wait
  a_stop_hold: assert property (
    tick_source_sel_reg == 3'h0 && !wr_count |=> $stable(count_value_reg))
    else $error("Counter moved while stopped");
  a_write_wins: assert property (
    wr_count |=> count_value_reg == $past(hwdata[7:0]))
    else $error("Counter write lost");
  a_normal_wrap: assert property (
    timer_tick && !wr_count && wave_mode_sel == timer8_pkg::WM_NORMAL && at_max
      |=> count_value_reg == `COUNT_BOTTOM && irq_flag_reg[`IRQ_OVF])
    else $error("Normal wrap or overflow flag wrong");
  a_match_flag: assert property (
    timer_tick && !wr_count && !block_reg && match_a |=> irq_flag_reg[`IRQ_CMP_A])
    else $error("Compare A flag not set");
  a_match_blocked: assert property (
    wr_count ##1 (timer_tick && !wr_count && irq_flag_reg == 3'h0 && !ovf_evt)
      |=> irq_flag_reg == 3'h0)
    else $error("Match not blocked after write");
  a_match_clear: assert property (
    timer_tick && !wr_count && wave_mode_sel == timer8_pkg::WM_CLEAR_MATCH && match_a
      |=> count_value_reg == `COUNT_BOTTOM)
    else $error("Clear on match failed");
  a_irq_gate: assert property (irq_match_b == (irq_flag_reg[2] && irq_mask_reg[2]))
    else $error("Request not flag and mask");
  a_bottom_flag: assert property (at_bottom |=> bottom_out)
    else $error("Bottom indication missing");
  a_read_wait: assert property (addr_phase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong");

  // Bus timing, count read-back and compare A and mask writes
  a_write_nowait: assert property (addr_phase && hwrite |=> hreadyout)
    else $error("Write wait state inserted");
  a_count_read: assert property (
    rd_pend_reg && addr_reg == `OFF_COUNT |=> hrdata[7:0] == $past(count_value_reg))
    else $error("Count read back wrong");
  a_cmp_write: assert property (
    wr_cmp_a |=> compare_value_a_reg == $past(hwdata[7:0]))
    else $error("Compare A write lost");
  a_mask_write: assert property (
    wr_mask |=> irq_mask_reg == $past(hwdata[2:0]))
    else $error("Mask write lost");

  // Step size, direction and overflow point per mode
  a_step_one: assert property (
    timer_tick && !wr_count
      |=> count_value_reg == $past(count_value_reg) + 8'h01
        || count_value_reg == $past(count_value_reg) - 8'h01
        || count_value_reg == `COUNT_BOTTOM)
    else $error("Counter step not one");
  a_dir_up_only: assert property (!is_pc |=> !dir_down_reg)
    else $error("Down count outside phase-correct mode");
  a_pc_turn: assert property (
    timer_tick && !wr_count && is_pc && at_top && !at_bottom |=> dir_down_reg)
    else $error("No turn at top");
  a_pc_overflow: assert property (
    timer_tick && !wr_count && is_pc && dir_down_reg && count_value_reg == `COUNT_ONE
      |=> count_value_reg == `COUNT_BOTTOM && irq_flag_reg[`IRQ_OVF])
    else $error("Phase-correct overflow wrong");
  a_fast_overflow: assert property (
    timer_tick && !wr_count && is_fast && at_top |=> irq_flag_reg[`IRQ_OVF])
    else $error("Fast mode overflow flag missing");

  // Flag clearing and request gating
  a_flag_clear: assert property (
    wr_flag && (hwdata[2:0] & set_vec) == 3'h0
      |=> (irq_flag_reg & $past(hwdata[2:0])) == 3'h0)
    else $error("Flag write of one did not clear");
  a_ovf_gate: assert property (irq_ovf == (irq_flag_reg[0] && irq_mask_reg[0]))
    else $error("Overflow request not flag and mask");
  a_cmpa_gate: assert property (
    irq_match_a == (irq_flag_reg[1] && irq_mask_reg[1]))
    else $error("Compare A request not flag and mask");

  // Indications toward the waveform generator
  a_top_flag: assert property (at_top |=> top_out)
    else $error("Top indication missing");
  a_match_out: assert property (match_b |=> match_b_out)
    else $error("Compare B indication missing");
  a_bottom_clear: assert property (!at_bottom |=> !bottom_out)
    else $error("Bottom indication stuck");

  // Main scenarios
  c_overflow: cover property (ovf_evt && wave_mode_sel == timer8_pkg::WM_NORMAL);
  c_clear_match: cover property (cmp_a_evt && wave_mode_sel == timer8_pkg::WM_CLEAR_MATCH);
  c_write_on_tick: cover property (wr_count && timer_tick);
  c_pc_turn: cover property (is_pc && timer_tick && at_top && !dir_down_reg);
endmodule // timer8_counter_core

// ===== testbench.sv
// Self-checking bench for the 8-bit timer core, driven through its AHB-Lite register port.
// Assumes timer8_params.svh and timer8_pkg are compiled ahead of this file.
`timescale 1ns/1ps
`include "timer8_params.svh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_count_pin = 1'b0;
  logic [2:0] irq_ack = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq_ovf, irq_match_a, irq_match_b;
  logic match_a_out, match_b_out, top_out, bottom_out, count_down_out;
  wire hready = hreadyout;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  logic saw_down = 1'b0;
  localparam int div_tab [4] = '{8, 64, 256, 1024};
  // Mode, count stays at or below compare A, overflow flag expected
  logic [4:0] mode_tab [5] = '{{3'h2, 2'b10}, {3'h7, 2'b11}, {3'h3, 2'b00}, {3'h1, 2'b00},
                               {3'h5, 2'b11}};

  timer8_counter_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext_count_pin), .irq_ack(irq_ack),
    .irq_ovf(irq_ovf), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
    .match_a_out(match_a_out), .match_b_out(match_b_out), .top_out(top_out),
    .bottom_out(bottom_out), .count_down_out(count_down_out)
  );

  // 40 MHz system clock
  always #12.5 hclk = ~hclk;

  // Cycle watchdog and capture of any down-counting phase
  always @(posedge hclk)
  begin
    cycles++;
    if (count_down_out === 1'b1) saw_down <= 1'b1;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Single AHB transfer; holds each phase until hready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    check(q, exp);
  endtask

  // Main sequence of register-level tests
  initial
  begin
    logic [31:0] q;
    logic [7:0] offs [8];
    logic [4:0] m;
    offs = '{`OFF_CTRL_A, `OFF_CTRL_B, `OFF_COUNT, `OFF_CMP_A, `OFF_CMP_B, `OFF_MASK,
             `OFF_FLAG, 8'h1C};
    run(10);
    hresetn <= 1'b1;
    run(1);
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("Test reset values done");
    // Full-word writes keep only the low byte
    wr(`OFF_COUNT, 32'h1234_56A5);
    wr(`OFF_CMP_A, 32'hFFFF_FF5A);
    wr(`OFF_CMP_B, 32'h0000_003C);
    rd_chk(`OFF_COUNT, 32'hA5);
    rd_chk(`OFF_CMP_A, 32'h5A);
    rd_chk(`OFF_CMP_B, 32'h3C);
    run(20);
    rd_chk(`OFF_COUNT, 32'hA5);
    $display("Test readback and stop done");
    // Prescaler taps: a window of two periods yields about two ticks
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFF_COUNT, 32'h0);
      wr(`OFF_CTRL_B, 32'h2 + i);
      run(2 * div_tab[i] - 2);
      wr(`OFF_CTRL_B, 32'h0);
      rd(`OFF_COUNT, q);
      check({31'h0, q[7:0] >= 8'h01 && q[7:0] <= 8'h03}, 32'h1);
    end
    $display("Test prescaler done");
    // Normal mode wraps past 0xFF and raises the overflow request
    wr(`OFF_COUNT, 32'hFC);
    wr(`OFF_CMP_A, 32'h80);
    wr(`OFF_CMP_B, 32'h80);
    wr(`OFF_FLAG, 32'h7);
    wr(`OFF_MASK, 32'h1);
    wr(`OFF_CTRL_B, 32'h1);
    run(8);
    wr(`OFF_CTRL_B, 32'h0);
    rd_chk(`OFF_FLAG, 32'h1);
    rd(`OFF_COUNT, q);
    check({31'h0, q[7:0] < 8'h10}, 32'h1);
    check({29'h0, irq_match_b, irq_match_a, irq_ovf}, 32'h1);
    irq_ack <= 3'h1;
    run(1);
    irq_ack <= 3'h0;
    run(2);
    check({31'h0, irq_ovf}, 32'h0);
    rd_chk(`OFF_FLAG, 32'h0);
    $display("Test overflow done");
    // A count write hides the match in the next tick; unit B still matches
    wr(`OFF_CMP_A, 32'h07);
    wr(`OFF_CMP_B, 32'h09);
    wr(`OFF_COUNT, 32'h07);
    wr(`OFF_FLAG, 32'h7);
    wr(`OFF_MASK, 32'h6);
    wr(`OFF_CTRL_B, 32'h1);
    run(6);
    wr(`OFF_CTRL_B, 32'h0);
    run(2);
    rd_chk(`OFF_FLAG, 32'h4);
    check({29'h0, irq_match_b, irq_match_a, irq_ovf}, 32'h4);
    wr(`OFF_FLAG, 32'h4);
    run(2);
    check({31'h0, irq_match_b}, 32'h0);
    // A write while counting takes effect over the tick and hides a match at its value
    wr(`OFF_CMP_B, 32'h80);
    wr(`OFF_COUNT, 32'h0);
    wr(`OFF_CTRL_B, 32'h1);
    run(5);
    wr(`OFF_COUNT, 32'h80);
    wr(`OFF_CTRL_B, 32'h0);
    rd(`OFF_COUNT, q);
    check({31'h0, q[7:0] >= 8'h80 && q[7:0] <= 8'h83}, 32'h1);
    rd_chk(`OFF_FLAG, 32'h0);
    $display("Test compare and write priority done");
    // Mode field split over both control registers decides top and overflow
    foreach (mode_tab[i])
    begin
      m = mode_tab[i];
      wr(`OFF_CTRL_B, 32'h0);
      wr(`OFF_CMP_A, 32'h05);
      wr(`OFF_COUNT, 32'h0);
      wr(`OFF_FLAG, 32'h7);
      wr(`OFF_CTRL_A, {30'h0, m[3:2]});
      wr(`OFF_CTRL_B, {28'h0, m[4], 3'h1});
      run(20);
      wr(`OFF_CTRL_B, {28'h0, m[4], 3'h0});
      rd(`OFF_COUNT, q);
      check({31'h0, q[7:0] <= 8'h05}, {31'h0, m[1]});
      rd(`OFF_FLAG, q);
      check({31'h0, q[0]}, {31'h0, m[0]});
      check({31'h0, q[1]}, 32'h1);
    end
    check({31'h0, saw_down}, 32'h1);
    // Service pulse clears only the compare A flag
    check({29'h0, irq_match_b, irq_match_a, irq_ovf}, 32'h2);
    irq_ack <= 3'h2;
    run(1);
    irq_ack <= 3'h0;
    rd_chk(`OFF_FLAG, 32'h1);
    check({31'h0, irq_match_a}, 32'h0);
    $display("Test modes done");
    // Bottom, top and match indications at fixed counts
    wr(`OFF_CTRL_A, 32'h0);
    wr(`OFF_CTRL_B, 32'h0);
    wr(`OFF_CMP_A, 32'h20);
    wr(`OFF_CMP_B, 32'h00);
    wr(`OFF_COUNT, 32'h00);
    run(2);
    check({29'h0, bottom_out, match_b_out, top_out}, 32'h6);
    wr(`OFF_COUNT, 32'hFF);
    run(2);
    check({29'h0, bottom_out, match_b_out, top_out}, 32'h1);
    wr(`OFF_COUNT, 32'h20);
    run(2);
    check({30'h0, match_a_out, top_out}, 32'h2);
    wr(`OFF_CTRL_A, 32'h2);
    run(2);
    check({31'h0, top_out}, 32'h1);
    wr(`OFF_CTRL_A, 32'h0);
    $display("Test indications done");
    // External pin: three pulses give three ticks on either edge
    for (int s = 6; s < 8; s++)
    begin
      wr(`OFF_COUNT, 32'h0);
      wr(`OFF_CTRL_B, s);
      repeat (3)
      begin
        ext_count_pin <= 1'b1;
        run(4);
        ext_count_pin <= 1'b0;
        run(4);
      end
      run(6);
      wr(`OFF_CTRL_B, 32'h0);
      rd_chk(`OFF_COUNT, 32'h3);
    end
    $display("Test external pin done");
    print_verdict();
  end
endmodule // testbench
